// ==== kse_cpu_model.sv ====
// CPU side model: timing pulse and input instruction selects
`timescale 1ns/1ps
module kse_cpu_model (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        rdReq,
  output logic       cpuTimingPulse,
  output logic       memoryReadStrobe,
  output logic [2:0] ioSelectLines,
  output logic       rdDone
);
  logic [2:0] phase;
  logic       busy;
  // Pulse every eight clocks keeps scans short
  assign cpuTimingPulse = phase[2];
  always @(posedge sys_clk) begin
    rdDone <= 1'h0;
    if (srst) begin
      phase <= 3'h0;
      busy <= 1'h0;
      memoryReadStrobe <= 1'h0;
      ioSelectLines <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
      if (phase == 3'h7 && busy) begin
        busy <= 1'h0;
        memoryReadStrobe <= 1'h0;
        ioSelectLines <= 3'h0;
        rdDone <= 1'h1;
      end else if (phase == 3'h7 && rdReq && !rdDone) begin
        // Selects span a whole pulse, one rise inside
        busy <= 1'h1;
        memoryReadStrobe <= 1'h1;
        ioSelectLines <= 3'h5;
      end
    end
  end
endmodule // kse_cpu_model

// ==== kse_defines.vh ====
// Constants for the keyboard scan encoder
`ifndef KSE_DEFINES_VH
`define KSE_DEFINES_VH

`define KSE_DRIVE_LINES   11
`define KSE_SENSE_LINES   8
`define KSE_ASCII_DRIVES  7
`define KSE_LAST_DRIVE    4'hA
`define KSE_IO_PORT       3'h5

`define KSE_ADDR_CFG      12'h000
`define KSE_ADDR_STATUS   12'h004
`define KSE_ADDR_CODE     12'h008
`define KSE_ADDR_IRQ_STAT 12'h00C
`define KSE_ADDR_IRQ_MASK 12'h010

`define KSE_CFG_CLOSE_LSB 0
`define KSE_CFG_REL_LSB   16
`define KSE_CLOSE_RST     16'h0004
`define KSE_REL_RST       16'h0004

`define KSE_IRQ_READY     0
`define KSE_IRQ_REPEAT    1
`define KSE_IRQ_READ      2
`define KSE_IRQ_W         3

`define KSE_ST_SCAN       3'h0
`define KSE_ST_CLOSE_DB   3'h1
`define KSE_ST_HELD       3'h2
`define KSE_ST_REL_DB     3'h3
`define KSE_ST_WAIT_READ  3'h4

`endif

// ==== kse_keyboard_encoder.v ====
// Keyboard matrix scan encoder with APB status and control registers
// Function
// - Control overrides shift and caps lock; uncoded control positions give nothing.
// - Drive lines eight to eleven yield hex special codes, not ASCII.
// - Scan counter raises exactly one of eleven drive lines at a time.
// - Sense counter selects which of eight sense lines is sampled.
// - Valid closure stops scanning at next timing rise; key ready falls after closure debounce.
// - Frozen scan position forms the eight bit key code on data pins.
// - Data pins driven in the cycle after each cycle of a selected CPU input instruction.
// - Timing rise during selected input returns key ready high.
// - Key ready stays high until release and a fresh closure.
// - Scan resumes after release, release debounce and read, on timing falls.
// - First closed key in scan order wins; others ignored until released.
// - Key still closed after read lowers repeat flag on timing rise.
// - Repeat flag returns high when release debounce ends.
// - Closure debounce ends by latching key ready low and the shift and control keys.
// - Release ends closure debounce and starts separate release debounce.
// - Shift and control latched after debounce; caps lock used live.
// - Repeat flag active low, held while key stays closed after read.
`timescale 1ns/1ps
`include "kse_defines.vh"

module kse_keyboard_encoder #(
  parameter [2:0] IO_PORT = `KSE_IO_PORT
) (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        cpuTimingPulse,
  input  wire        memoryReadStrobe,
  input  wire [2:0]  ioSelectLines,
  input  wire [7:0]  scanSenseLines,
  input  wire        shiftKey,
  input  wire        controlKey,
  input  wire        alphaLock,
  output reg  [10:0] scanDriveLines,
  output reg  [7:0]  keyCodeBits,
  output reg         keyCodeOe,
  output reg         keyReady_n,
  output reg         autorepeatFlag_n,
  output reg         irq
);

  localparam [2:0] ST_SCAN      = `KSE_ST_SCAN;
  localparam [2:0] ST_CLOSE_DB  = `KSE_ST_CLOSE_DB;
  localparam [2:0] ST_HELD      = `KSE_ST_HELD;
  localparam [2:0] ST_REL_DB    = `KSE_ST_REL_DB;
  localparam [2:0] ST_WAIT_READ = `KSE_ST_WAIT_READ;

  // Register decode, shared by the read mux, the write side and the clear path
  function [4:0] regSel;
    input [11:0] addr;
    begin
      if (addr == `KSE_ADDR_CFG)
        regSel = 5'h01;
      else if (addr == `KSE_ADDR_STATUS)
        regSel = 5'h02;
      else if (addr == `KSE_ADDR_CODE)
        regSel = 5'h04;
      else if (addr == `KSE_ADDR_IRQ_STAT)
        regSel = 5'h08;
      else if (addr == `KSE_ADDR_IRQ_MASK)
        regSel = 5'h10;
      else
        regSel = 5'h00;
    end
  endfunction

  // Hex block: eight codes per drive line, modifiers have no effect here
  function [7:0] hexKey;
    input [3:0] drv;
    input [2:0] sns;
    begin
      if (drv == 4'h7)
        hexKey = 8'h80 + {5'h00, sns};
      else if (drv == 4'h8)
        hexKey = 8'h88 + {5'h00, sns};
      else if (drv == 4'h9)
        hexKey = 8'h90 + {5'h00, sns};
      else
        hexKey = 8'h98 + {5'h00, sns};
    end
  endfunction

  // Seventh drive line: fixed codes, blank positions give no response
  function [8:0] specialKey;
    input [2:0] sns;
    begin
      case (sns)
        3'h0:    specialKey = {1'b1, 8'h20};
        3'h2:    specialKey = {1'b1, 8'h0A};
        3'h3:    specialKey = {1'b1, 8'h1B};
        3'h5:    specialKey = {1'b1, 8'h0D};
        3'h7:    specialKey = {1'b1, 8'h7F};
        default: specialKey = {1'b0, 8'h00};
      endcase
    end
  endfunction

  // Returns {valid, code}; valid low means no response for this position
  function [8:0] encodeKey;
    input [3:0] drv;
    input [2:0] sns;
    input       shf;
    input       ctl;
    input       alp;
    reg   [7:0] base;
    reg         letter;
    begin
      base   = 8'h30 + {1'b0, drv[2:0], sns};
      letter = (base >= 8'h41) && (base <= 8'h5A);
      encodeKey = {1'b0, 8'h00};
      if (drv >= 4'h7) begin
        encodeKey = {1'b1, hexKey(drv, sns)};
      end else if (drv == 4'h6) begin
        encodeKey = specialKey(sns);
      end else if (ctl) begin
        if (drv >= 4'h2)
          encodeKey = {1'b1, base - 8'h40};
        else
          encodeKey = {1'b0, 8'h00};
      end else if (shf) begin
        if (drv <= 4'h1)
          encodeKey = {1'b1, base ^ 8'h10};
        else if (base >= 8'h5B)
          encodeKey = {1'b1, base + 8'h20};
        else
          encodeKey = {1'b1, base};
      end else if (alp && letter) begin
        encodeKey = {1'b1, base};
      end else if (letter || base >= 8'h5B) begin
        encodeKey = {1'b1, base + 8'h20};
      end else begin
        encodeKey = {1'b1, base};
      end
    end
  endfunction

  reg  [2:0]  state;
  reg  [3:0]  driveCnt;
  reg  [2:0]  senseCnt;
  reg         pulseLast;
  reg  [15:0] dbCount;
  reg  [15:0] closeCount;
  reg  [15:0] releaseCount;
  reg         shiftHeld;
  reg         controlHeld;
  reg  [`KSE_IRQ_W-1:0] irqStat;
  reg  [`KSE_IRQ_W-1:0] irqMask;

  wire        pulseRise = cpuTimingPulse & ~pulseLast;
  wire        pulseFall = ~cpuTimingPulse & pulseLast;
  wire        selected  = memoryReadStrobe && (ioSelectLines == IO_PORT);
  wire        readStrobe = pulseRise & selected;
  wire        keyClosed = scanSenseLines[senseCnt];
  // Code uses latched modifiers except caps lock, which is live
  wire [8:0]  liveCode = encodeKey(driveCnt, senseCnt, shiftKey, controlKey, alphaLock);
  wire [8:0]  heldCode = encodeKey(driveCnt, senseCnt, shiftHeld, controlHeld, alphaLock);
  wire        apbAccess = psel & penable & pready;
  wire        apbWrite  = apbAccess & pwrite;
  wire [4:0]  hitSel    = regSel(paddr);
  reg         evReady;
  reg         evRepeat;
  reg         evRead;

  // Timing pulse edge detect; the pin is taken as synchronous
  always @(posedge sys_clk) begin
    if (srst) begin
      pulseLast <= 1'b0;
    end else begin
      pulseLast <= cpuTimingPulse;
    end
  end

  // Scan and key handshake sequencer
  always @(posedge sys_clk) begin
    if (srst) begin
      state            <= ST_SCAN;
      driveCnt         <= 4'h0;
      senseCnt         <= 3'h0;
      dbCount          <= 16'h0000;
      shiftHeld        <= 1'b0;
      controlHeld      <= 1'b0;
      keyCodeBits      <= 8'h00;
      keyReady_n       <= 1'b1;
      autorepeatFlag_n <= 1'b1;
      evReady          <= 1'b0;
      evRepeat         <= 1'b0;
      evRead           <= 1'b0;
    end else begin
      evReady  <= 1'b0;
      evRepeat <= 1'b0;
      evRead   <= 1'b0;
      if (readStrobe && !keyReady_n) begin
        keyReady_n <= 1'b1;
        evRead     <= 1'b1;
      end
      case (state)
        ST_SCAN: begin
          // Uncoded control positions are skipped, so they never lock
          if (pulseRise && keyClosed && liveCode[8]) begin
            state   <= ST_CLOSE_DB;
            dbCount <= 16'h0000;
          end else if (pulseFall) begin
            if (senseCnt == 3'h7) begin
              senseCnt <= 3'h0;
              driveCnt <= (driveCnt == `KSE_LAST_DRIVE) ? 4'h0 : driveCnt + 4'h1;
            end else begin
              senseCnt <= senseCnt + 3'h1;
            end
          end
        end
        ST_CLOSE_DB: begin
          if (!keyClosed) begin
            state   <= ST_REL_DB;
            dbCount <= 16'h0000;
          end else if (pulseRise) begin
            if (dbCount + 16'h0001 >= closeCount) begin
              state       <= ST_HELD;
              keyReady_n  <= 1'b0;
              evReady     <= 1'b1;
              shiftHeld   <= shiftKey;
              controlHeld <= controlKey;
            end else begin
              dbCount <= dbCount + 16'h0001;
            end
          end
        end
        ST_HELD: begin
          keyCodeBits <= heldCode[7:0];
          if (!keyClosed) begin
            state   <= ST_REL_DB;
            dbCount <= 16'h0000;
          end else if (keyReady_n && autorepeatFlag_n && pulseRise) begin
            autorepeatFlag_n <= 1'b0;
            evRepeat         <= 1'b1;
          end
        end
        ST_REL_DB: begin
          // Scan counters stay frozen here while dbCount counts, which gives the lockout
          if (pulseRise) begin
            if (dbCount + 16'h0001 >= releaseCount) begin
              autorepeatFlag_n <= 1'b1;
              if (keyReady_n && !readStrobe)
                state <= ST_SCAN;
              else
                state <= ST_WAIT_READ;
            end else begin
              dbCount <= dbCount + 16'h0001;
            end
          end
        end
        ST_WAIT_READ: begin
          // A slow CPU keeps every later key locked out
          if (keyReady_n)
            state <= ST_SCAN;
        end
        default: begin
          state <= ST_SCAN;
        end
      endcase
    end
  end

  // Drive lines, one hot from the frozen or running drive count
  always @(posedge sys_clk) begin
    if (srst) begin
      scanDriveLines <= 11'h000;
    end else begin
      scanDriveLines <= 11'h001 << driveCnt;
    end
  end

  // Data pin enable; one cycle late, but straight from a flip-flop
  always @(posedge sys_clk) begin
    if (srst) begin
      keyCodeOe <= 1'b0;
    end else begin
      keyCodeOe <= selected;
    end
  end

  // Sticky events: a set in the same cycle as a clear wins
  always @(posedge sys_clk) begin
    if (srst) begin
      irqStat <= {`KSE_IRQ_W{1'b0}};
      irq     <= 1'b0;
    end else begin
      irqStat <= (irqStat & ~((apbWrite && hitSel[3]) ?
                 pwdata[`KSE_IRQ_W-1:0] : {`KSE_IRQ_W{1'b0}}))
                 | {evRead, evRepeat, evReady};
      irq     <= |(irqStat & irqMask);
    end
  end

  // APB slave, one wait state per access
  always @(posedge sys_clk) begin
    if (srst) begin
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= 32'h00000000;
      closeCount   <= `KSE_CLOSE_RST;
      releaseCount <= `KSE_REL_RST;
      irqMask      <= {`KSE_IRQ_W{1'b0}};
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      // Registered answer costs a wait state but keeps decode off the return path
      if (psel && penable && !pready) begin
        if (hitSel[0]) begin
          prdata <= {releaseCount, closeCount};
        end else if (hitSel[1]) begin
          prdata <= {16'h0000, 1'b0, state, driveCnt, senseCnt,
                     autorepeatFlag_n, keyReady_n, 3'h0};
        end else if (hitSel[2]) begin
          prdata <= {24'h000000, keyCodeBits};
        end else if (hitSel[3]) begin
          prdata <= {29'h00000000, irqStat};
        end else if (hitSel[4]) begin
          prdata <= {29'h00000000, irqMask};
        end else begin
          pslverr <= 1'b1;
        end
      end
      if (apbWrite) begin
        if (hitSel[0]) begin
          closeCount   <= pwdata[`KSE_CFG_CLOSE_LSB +: 16];
          releaseCount <= pwdata[`KSE_CFG_REL_LSB +: 16];
        end else if (hitSel[4]) begin
          irqMask <= pwdata[`KSE_IRQ_W-1:0];
        end
      end
    end
  end

endmodule // kse_keyboard_encoder

// ==== kse_keyboard_encoder_tb.sv ====
// Testbench for the keyboard scan encoder
`timescale 1ns/1ps
module kse_keyboard_encoder_tb;
  logic        sys_clk = 1'h0;
  logic        srst = 1'h1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic        rdReq = 1'h0;
  logic        shiftKey = 1'h0;
  logic        controlKey = 1'h0;
  logic        alphaLock = 1'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, rdDone, irq, keyCodeOe, keyReady_n, autorepeatFlag_n;
  logic        cpuTimingPulse, memoryReadStrobe;
  logic [2:0]  ioSelectLines;
  logic [7:0]  scanSenseLines, keyCodeBits;
  logic [10:0] scanDriveLines;
  logic [7:0]  keyMat [0:10];
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  kse_keyboard_encoder dut_u (.sys_clk, .srst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .cpuTimingPulse, .memoryReadStrobe,
    .ioSelectLines, .scanSenseLines, .shiftKey, .controlKey, .alphaLock,
    .scanDriveLines, .keyCodeBits, .keyCodeOe, .keyReady_n, .autorepeatFlag_n, .irq);
  kse_cpu_model cpu_u (.sys_clk, .srst, .rdReq, .cpuTimingPulse, .memoryReadStrobe,
    .ioSelectLines, .rdDone);
  always #2 sys_clk = ~sys_clk;
  // Switch matrix: a closed key shorts its drive to its sense line
  always_comb begin
    scanSenseLines = 8'h00;
    for (int i = 0; i < 11; i++) if (scanDriveLines[i]) scanSenseLines |= keyMat[i];
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task take(input int d, input int s, input logic [7:0] code, input logic [7:0] msk);
    @(posedge sys_clk);
    keyMat[d][s] <= 1'h1;
    while (keyReady_n !== 1'h0) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'h1);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd & {24'h000000, msk}, {24'h000000, code});
    rdReq <= 1'h1;
    while (keyCodeOe !== 1'h1) @(posedge sys_clk);
    chk(keyCodeBits & msk, code);
    while (rdDone !== 1'h1) @(posedge sys_clk);
    rdReq <= 1'h0;
    chk(keyReady_n, 1'h1);
    while (autorepeatFlag_n !== 1'h0) @(posedge sys_clk);
    chk(keyReady_n, 1'h1);
    keyMat[d][s] <= 1'h0;
    while (autorepeatFlag_n !== 1'h1) @(posedge sys_clk);
    apb(1'h0, 12'h00C, 32'h0);
    chk(rd, 32'h0000_0007);
    apb(1'h1, 12'h00C, 32'h7);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'h0);
    $display("key test done code %h", code);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Whole run needs about 3000 clocks
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      stop_test;
    end
  end
  initial begin
    for (int i = 0; i < 11; i++) keyMat[i] = 8'h00;
    repeat (20) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    chk({keyCodeOe, keyReady_n, autorepeatFlag_n, scanDriveLines}, 14'h1800);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0004_0004);
    apb(1'h1, 12'h000, 32'h0002_0003);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0002_0003);
    apb(1'h0, 12'h020, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0);
    apb(1'h1, 12'h010, 32'h7);
    $display("register test done");
    take(2, 5, 8'h65, 8'hFF);
    take(7, 2, 8'h82, 8'hFF);
    keyMat[9][0] <= 1'h1;
    take(8, 3, 8'h8B, 8'hFF);
    take(9, 0, 8'h90, 8'hFF);
    shiftKey <= 1'h1;
    take(2, 5, 8'h45, 8'hFF);
    shiftKey <= 1'h0;
    alphaLock <= 1'h1;
    take(2, 5, 8'h45, 8'hFF);
    alphaLock <= 1'h0;
    controlKey <= 1'h1;
    keyMat[0][1] <= 1'h1;
    take(2, 5, 8'h05, 8'hFF);
    controlKey <= 1'h0;
    keyMat[0][1] <= 1'h0;
    stop_test;
  end
endmodule // kse_keyboard_encoder_tb

// ==== kse_keyboard_monitor.sv ====
// Assertion checker for the keyboard scan encoder
`timescale 1ns/1ps
module kse_keyboard_monitor #(
  parameter [2:0] IO_PORT = 3'h5
) (
  input wire        sys_clk,
  input wire        srst,
  input wire        memoryReadStrobe,
  input wire [2:0]  ioSelectLines,
  input wire [7:0]  scanSenseLines,
  input wire [10:0] scanDriveLines,
  input wire [7:0]  keyCodeBits,
  input wire        keyCodeOe,
  input wire        keyReady_n,
  input wire        autorepeatFlag_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  one_drive_a: assert property ($onehot0(scanDriveLines))
    else $error("more than one drive line high");
  oe_select_a: assert property (keyCodeOe |->
    $past(memoryReadStrobe && ioSelectLines == IO_PORT)) else $error("data pins driven unselected");
  scan_hold_a: assert property (!keyReady_n && $past(!keyReady_n) |->
    $stable(scanDriveLines)) else $error("scan moved while key ready");
  code_class_a: assert property (!keyReady_n && $past(!keyReady_n) |->
    keyCodeBits[7] == (scanDriveLines[10:7] != 4'h0)) else $error("code class wrong");
  ready_read_a: assert property ($rose(keyReady_n) |-> $past(memoryReadStrobe)
    || $past(memoryReadStrobe, 2) || $past(memoryReadStrobe, 3)) else $error("ready rose unread");
  rpt_set_a: assert property ($fell(autorepeatFlag_n) |->
    keyReady_n && scanSenseLines != 8'h00) else $error("repeat without held key");
  rpt_hold_a: assert property (!autorepeatFlag_n |->
    keyReady_n && $stable(scanDriveLines)) else $error("scan moved during repeat");
  rpt_clear_a: assert property ($rose(autorepeatFlag_n) |->
    $past(scanSenseLines) == 8'h00) else $error("repeat cleared with key down");
  reset_state_a: assert property (disable iff (1'h0) srst |=> keyReady_n &&
    autorepeatFlag_n && !keyCodeOe && scanDriveLines == 11'h000) else $error("bad reset state");
endmodule // kse_keyboard_monitor
bind kse_keyboard_encoder kse_keyboard_monitor #(.IO_PORT(IO_PORT)) mon_u (
  .sys_clk, .srst, .memoryReadStrobe, .ioSelectLines, .scanSenseLines,
  .scanDriveLines, .keyCodeBits, .keyCodeOe, .keyReady_n, .autorepeatFlag_n);
